/* File: include/spd_pkg.sv */
package spd_pkg;
   localparam int APB_ADDR_W = 12;
   localparam int APB_DATA_W = 32;
   localparam int PORT_W = 8;
   localparam int NUM_PORTS = 4;
   localparam int PINS_W = PORT_W * NUM_PORTS;
   localparam int CNT_W = 8;

   // register indices; byte address is four times the index
   localparam logic [9:0] PWR_CTRL_IDX = 10'h087;
   localparam logic [9:0] IO_CTRL_IDX = 10'h0F8;
   localparam logic [9:0] WAKE_EN_IDX = 10'h040;
   localparam logic [9:0] TMR_CTRL_IDX = 10'h041;
   localparam logic [9:0] TMR_CNT_IDX = 10'h042;
   localparam logic [9:0] STATUS_IDX = 10'h043;

   // power control register fields
   localparam int PWR_DOWN_BIT = 1;
   localparam int PWR_WAKE_ANY_BIT = 5;
   // io control register fields
   localparam int IO_FLOAT_BIT = 0;
   // wake enable / cancel source positions
   localparam int SRC_IRQ0 = 0;
   localparam int SRC_IRQ1 = 1;
   localparam int SRC_TMR0 = 2;
   localparam int SRC_TMR1 = 3;
   // timer control fields
   localparam int TC_RUN0_BIT = 0;
   localparam int TC_EXT0_BIT = 1;
   localparam int TC_RUN1_BIT = 2;
   localparam int TC_EXT1_BIT = 3;
   // status fields
   localparam int ST_DOWN_BIT = 0;
   localparam int ST_REFUSED_BIT = 1;
   localparam int ST_OVF0_BIT = 2;
   localparam int ST_OVF1_BIT = 3;

   localparam logic [CNT_W-1:0] CNT_ALL_ONES = 8'hFF;
   localparam logic [CNT_W-1:0] CNT_RESET = 8'h00;
   localparam logic [3:0] WAKE_EN_RESET = 4'h0;
   localparam logic [3:0] TMR_CTRL_RESET = 4'h0;
   localparam logic [PINS_W-1:0] PINS_ALL = 32'hFFFF_FFFF;
   localparam logic [PINS_W-1:0] PINS_NONE = 32'h0000_0000;
   // port 3 pins 2..5 stay live inputs while floating
   localparam logic [PINS_W-1:0] P3_WAKE_INPUTS = 32'h3C00_0000;
   // port 0 occupies the lowest byte
   localparam logic [PINS_W-1:0] PORT0_PINS = 32'h0000_00FF;
   localparam logic [APB_DATA_W-1:0] DATA_ZERO = 32'h0000_0000;

   typedef enum logic {SPD_RUN, SPD_POWERDOWN} spd_mode_t;
endpackage : spd_pkg

/* File: include/spd_cnt_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface spd_cnt_if #(parameter int CNT_W = 8);
   logic countPin;
   logic run;
   logic extMode;
   logic halted;
   logic load;
   logic [CNT_W-1:0] loadVal;
   logic [CNT_W-1:0] count;
   logic overflow;
   modport ctr(input countPin, run, extMode, halted, load, loadVal, output count, overflow);
   modport ctl(output countPin, run, extMode, halted, load, loadVal, input count, overflow);
endinterface : spd_cnt_if
`default_nettype wire

/* File: design/spd_counter.sv */
`timescale 1ns/10ps
`default_nettype none
module spd_counter #(
   parameter int CNT_W = spd_pkg::CNT_W
) (
   input wire logic core_clk,
   input wire logic sys_rst,
   spd_cnt_if.ctr cnt
);
   logic prevPin;
   logic tick;
   logic [CNT_W-1:0] allOnes;

   if (CNT_W < 2) begin : g_chk
      $error("spd_counter: CNT_W must be at least 2");
   end

   assign allOnes = {CNT_W{1'b1}};
   // external mode keeps counting pin edges while the core clock domain is halted
   assign tick = cnt.run & (cnt.extMode ? (cnt.countPin & ~prevPin) : ~cnt.halted);

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         prevPin <= 1'b0;
      end else begin
         prevPin <= cnt.countPin;
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cnt.count <= '0;
      end else if (cnt.load) begin
         cnt.count <= cnt.loadVal;
      end else if (tick) begin
         cnt.count <= cnt.count + 1'b1;
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cnt.overflow <= 1'b0;
      end else begin
         cnt.overflow <= tick & ~cnt.load & (cnt.count == allOnes);
      end
   end
endmodule : spd_counter
`default_nettype wire

/* File: design/spd_power_ctrl.sv */
// The register addresses and register access over APB were decided locally.
`timescale 1ns/10ps
`default_nettype none
module spd_power_ctrl (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [spd_pkg::APB_ADDR_W-1:0] paddr,
   input wire logic [spd_pkg::APB_DATA_W-1:0] pwdata,
   output logic [spd_pkg::APB_DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic extIrqPinZero,
   input wire logic extIrqPinOne,
   input wire logic countPinZero,
   input wire logic countPinOne,
   input wire logic extRomMode,
   input wire logic wakeRequest,
   input wire logic [spd_pkg::PINS_W-1:0] portLatch,
   input wire logic [spd_pkg::PINS_W-1:0] portOutRun,
   input wire logic [spd_pkg::PINS_W-1:0] portOeRun,
   input wire logic fetchStrobeRun,
   input wire logic latchStrobeRun,
   output logic [spd_pkg::PINS_W-1:0] portOut,
   output logic [spd_pkg::PINS_W-1:0] portOe,
   output logic [spd_pkg::PINS_W-1:0] portInEn,
   output logic programFetchStrobe,
   output logic addressLatchStrobe,
   output logic oscHalt
);
   spd_pkg::spd_mode_t mode;
   logic wakeOnAnyFlag;
   logic portFloatSelect;
   logic floatAtEntry;
   logic entryRefused;
   logic [1:0] ovfFlag;
   logic [3:0] wakeEn;
   logic [3:0] tmrCtrl;
   logic [3:0] cancellable;
   logic [9:0] regIdx;
   logic accessPhase;
   logic setupPhase;
   logic wrAccess;
   logic mapped;
   logic [spd_pkg::APB_DATA_W-1:0] readMux;
   logic pwrCtrlWrite;
   logic downRequest;
   logic irqBlock;
   logic tmrBlock;
   logic refuse;
   logic enterNow;
   logic statusWrite;
   logic [spd_pkg::PINS_W-1:0] next_portOut;
   logic [spd_pkg::PINS_W-1:0] next_portOe;
   logic [spd_pkg::PINS_W-1:0] next_portInEn;
   logic next_fetch;
   logic next_latch;

   spd_cnt_if #(.CNT_W(spd_pkg::CNT_W)) tmr0 ();
   spd_cnt_if #(.CNT_W(spd_pkg::CNT_W)) tmr1 ();

   // ---------------- APB slave, zero wait states ----------------
   assign regIdx = paddr[11:2];
   assign setupPhase = psel & ~penable;
   assign accessPhase = psel & penable;
   assign wrAccess = accessPhase & pwrite;
   assign pready = 1'b1;
   assign pslverr = accessPhase & ~mapped;

   always_comb begin
      mapped = 1'b1;
      readMux = spd_pkg::DATA_ZERO;
      case (regIdx)
         spd_pkg::PWR_CTRL_IDX: begin
            readMux[spd_pkg::PWR_DOWN_BIT] = (mode == spd_pkg::SPD_POWERDOWN);
            readMux[spd_pkg::PWR_WAKE_ANY_BIT] = wakeOnAnyFlag;
         end
         spd_pkg::IO_CTRL_IDX: begin
            readMux[spd_pkg::IO_FLOAT_BIT] = portFloatSelect;
         end
         spd_pkg::WAKE_EN_IDX: begin
            readMux[3:0] = wakeEn;
         end
         spd_pkg::TMR_CTRL_IDX: begin
            readMux[3:0] = tmrCtrl;
         end
         spd_pkg::TMR_CNT_IDX: begin
            readMux[15:0] = {tmr1.count, tmr0.count};
         end
         spd_pkg::STATUS_IDX: begin
            readMux[spd_pkg::ST_DOWN_BIT] = (mode == spd_pkg::SPD_POWERDOWN);
            readMux[spd_pkg::ST_REFUSED_BIT] = entryRefused;
            readMux[spd_pkg::ST_OVF0_BIT] = ovfFlag[0];
            readMux[spd_pkg::ST_OVF1_BIT] = ovfFlag[1];
         end
         default: begin
            mapped = 1'b0;
         end
      endcase
   end

   // read data is captured in the setup cycle so it is a flop during access
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         prdata <= spd_pkg::DATA_ZERO;
      end else if (setupPhase && !pwrite) begin
         prdata <= readMux;
      end
   end

   // ---------------- configuration registers ----------------
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         wakeOnAnyFlag <= 1'b0;
      end else if (pwrCtrlWrite) begin
         wakeOnAnyFlag <= pwdata[spd_pkg::PWR_WAKE_ANY_BIT];
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         portFloatSelect <= 1'b0;
      end else if (wrAccess && regIdx == spd_pkg::IO_CTRL_IDX) begin
         portFloatSelect <= pwdata[spd_pkg::IO_FLOAT_BIT];
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         wakeEn <= spd_pkg::WAKE_EN_RESET;
      end else if (wrAccess && regIdx == spd_pkg::WAKE_EN_IDX) begin
         wakeEn <= pwdata[3:0];
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         tmrCtrl <= spd_pkg::TMR_CTRL_RESET;
      end else if (wrAccess && regIdx == spd_pkg::TMR_CTRL_IDX) begin
         tmrCtrl <= pwdata[3:0];
      end
   end

   // ---------------- timers 0 and 1 ----------------
   assign tmr0.countPin = countPinZero;
   assign tmr0.run = tmrCtrl[spd_pkg::TC_RUN0_BIT];
   assign tmr0.extMode = tmrCtrl[spd_pkg::TC_EXT0_BIT];
   assign tmr0.halted = oscHalt;
   assign tmr0.load = wrAccess && (regIdx == spd_pkg::TMR_CNT_IDX);
   assign tmr0.loadVal = pwdata[7:0];
   assign tmr1.countPin = countPinOne;
   assign tmr1.run = tmrCtrl[spd_pkg::TC_RUN1_BIT];
   assign tmr1.extMode = tmrCtrl[spd_pkg::TC_EXT1_BIT];
   assign tmr1.halted = oscHalt;
   assign tmr1.load = wrAccess && (regIdx == spd_pkg::TMR_CNT_IDX);
   assign tmr1.loadVal = pwdata[15:8];

   spd_counter #(.CNT_W(spd_pkg::CNT_W)) u_tmr0 (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .cnt(tmr0.ctr)
   );

   spd_counter #(.CNT_W(spd_pkg::CNT_W)) u_tmr1 (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .cnt(tmr1.ctr)
   );

   // ---------------- entry decision ----------------
   assign cancellable = wakeEn | {4{wakeOnAnyFlag}};
   assign pwrCtrlWrite = wrAccess && (regIdx == spd_pkg::PWR_CTRL_IDX);
   assign downRequest = pwrCtrlWrite & pwdata[spd_pkg::PWR_DOWN_BIT];
   // a low pin blocks whenever its source is enabled or wake-on-any is set
   assign irqBlock = (cancellable[spd_pkg::SRC_IRQ0] & ~extIrqPinZero)
                   | (cancellable[spd_pkg::SRC_IRQ1] & ~extIrqPinOne);
   assign tmrBlock = (cancellable[spd_pkg::SRC_TMR0] & tmr0.extMode
                      & (tmr0.count == spd_pkg::CNT_ALL_ONES) & countPinZero)
                   | (cancellable[spd_pkg::SRC_TMR1] & tmr1.extMode
                      & (tmr1.count == spd_pkg::CNT_ALL_ONES) & countPinOne);
   assign refuse = irqBlock | tmrBlock;
   assign enterNow = (mode == spd_pkg::SPD_RUN) & downRequest & ~refuse;

   // entry wins over a wake arriving in the same cycle
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         mode <= spd_pkg::SPD_RUN;
      end else begin
         case (mode)
            spd_pkg::SPD_RUN: begin
               if (enterNow) begin
                  mode <= spd_pkg::SPD_POWERDOWN;
               end
            end
            spd_pkg::SPD_POWERDOWN: begin
               if (wakeRequest) begin
                  mode <= spd_pkg::SPD_RUN;
               end
            end
            default: begin
               mode <= spd_pkg::SPD_RUN;
            end
         endcase
      end
   end

   // the float choice is frozen at entry so a late write cannot change the pins
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         floatAtEntry <= 1'b0;
      end else if (enterNow) begin
         floatAtEntry <= portFloatSelect;
      end
   end

   assign statusWrite = wrAccess && (regIdx == spd_pkg::STATUS_IDX);

   // sticky flags clear by writing one; a new event in the same cycle wins
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         entryRefused <= 1'b0;
      end else if (downRequest && refuse) begin
         entryRefused <= 1'b1;
      end else if (statusWrite && pwdata[spd_pkg::ST_REFUSED_BIT]) begin
         entryRefused <= 1'b0;
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         ovfFlag <= 2'b00;
      end else begin
         ovfFlag <= (ovfFlag & ~({2{statusWrite}}
                    & pwdata[spd_pkg::ST_OVF1_BIT:spd_pkg::ST_OVF0_BIT]))
                    | {tmr1.overflow, tmr0.overflow};
      end
   end

   // ---------------- pin control ----------------
   assign oscHalt = (mode == spd_pkg::SPD_POWERDOWN);

   always_comb begin
      next_portOut = portOutRun;
      next_portOe = portOeRun;
      next_portInEn = spd_pkg::PINS_ALL;
      next_fetch = fetchStrobeRun;
      next_latch = latchStrobeRun;
      if (mode == spd_pkg::SPD_POWERDOWN) begin
         next_fetch = 1'b0;
         next_latch = 1'b0;
         next_portOut = portLatch;
         if (floatAtEntry) begin
            next_portOe = spd_pkg::PINS_NONE;
            next_portInEn = spd_pkg::P3_WAKE_INPUTS;
         end else begin
            next_portOe = spd_pkg::PINS_ALL;
            if (extRomMode) begin
               next_portOe = ~spd_pkg::PORT0_PINS;
            end
         end
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         portOut <= spd_pkg::PINS_NONE;
         portOe <= spd_pkg::PINS_NONE;
         portInEn <= spd_pkg::PINS_ALL;
         programFetchStrobe <= 1'b0;
         addressLatchStrobe <= 1'b0;
      end else begin
         portOut <= next_portOut;
         portOe <= next_portOe;
         portInEn <= next_portInEn;
         programFetchStrobe <= next_fetch;
         addressLatchStrobe <= next_latch;
      end
   end
endmodule : spd_power_ctrl
`default_nettype wire

/* File: sim/spd_board_model.sv */
`timescale 1ns/10ps
`default_nettype none
module spd_board_model (
   input wire logic [31:0] portOut,
   input wire logic [31:0] portOe,
   output logic [31:0] pinLevel
);
   // board pull-ups: a released pin reads high, never its last driven value
   assign pinLevel = (portOut & portOe) | ~portOe;
endmodule : spd_board_model
`default_nettype wire

/* File: sim/spd_power_ctrl_properties.sv */
`timescale 1ns/10ps
`default_nettype none
module spd_power_ctrl_properties (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic extIrqPinZero,
   input wire logic extIrqPinOne,
   input wire logic extRomMode,
   input wire logic wakeRequest,
   input wire logic [31:0] portLatch,
   input wire logic [31:0] portOut,
   input wire logic [31:0] portOe,
   input wire logic [31:0] portInEn,
   input wire logic programFetchStrobe,
   input wire logic addressLatchStrobe,
   input wire logic oscHalt
);
   logic [3:0] wakeEn;
   logic wakeAny;
   logic flt;
   logic fltHeld;
   wire wr = psel && penable && pwrite;
   wire downReq = wr && paddr[11:2] == spd_pkg::PWR_CTRL_IDX && pwdata[1] && !oscHalt;
   wire [3:0] canc = wakeEn | {4{wakeAny}};
   // shadow of the registers that decide refusal and floating
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         wakeEn <= 4'h0;
         wakeAny <= 1'h0;
         flt <= 1'h0;
         fltHeld <= 1'h0;
      end else begin
         if (wr && paddr[11:2] == spd_pkg::WAKE_EN_IDX) wakeEn <= pwdata[3:0];
         if (wr && paddr[11:2] == spd_pkg::PWR_CTRL_IDX) wakeAny <= pwdata[5];
         if (wr && paddr[11:2] == spd_pkg::IO_CTRL_IDX) flt <= pwdata[0];
         if (downReq) fltHeld <= flt;
      end
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   sequence sHeld;
      oscHalt && $past(oscHalt);
   endsequence
   sequence sIrqBlock;
      downReq && ((canc[0] && !extIrqPinZero) || (canc[1] && !extIrqPinOne));
   endsequence
   chk_irq_refuse: assert property (sIrqBlock |=> !oscHalt)
      else $error("entry taken with wake pin low");
   chk_entry_taken: assert property (downReq && (extIrqPinZero || !canc[0])
      && (extIrqPinOne || !canc[1]) && canc[3:2] == 2'h0 |=> oscHalt)
      else $error("entry request ignored");
   chk_mode_held: assert property (oscHalt && !wakeRequest |=> oscHalt)
      else $error("power down left without wake");
   chk_strobes_low: assert property (sHeld |-> !programFetchStrobe && !addressLatchStrobe)
      else $error("strobe high in power down");
   chk_float_off: assert property (sHeld and fltHeld |-> portOe == spd_pkg::PINS_NONE)
      else $error("pin driven while floating");
   chk_float_inputs: assert property (sHeld and fltHeld |->
      portInEn == spd_pkg::P3_WAKE_INPUTS)
      else $error("wrong live inputs while floating");
   chk_hold_latch: assert property (sHeld and !fltHeld |-> portOut == $past(portLatch))
      else $error("pins not showing latched data");
   chk_rom_port0: assert property (sHeld and !fltHeld |->
      portOe == ($past(extRomMode) ? ~spd_pkg::PORT0_PINS : spd_pkg::PINS_ALL))
      else $error("wrong drive enables in power down");
endmodule : spd_power_ctrl_properties
bind spd_power_ctrl spd_power_ctrl_properties spd_power_ctrl_properties_inst (.*);
`default_nettype wire

/* File: sim/spd_power_ctrl_bench.sv */
`timescale 1ns/10ps
`default_nettype none
module spd_power_ctrl_bench;
   localparam logic [31:0] LATCH = 32'h5A3C_96E1;
   localparam logic [31:0] RUNV = 32'hA5C3_1E69;
   logic core_clk = 1'h0;
   logic sys_rst = 1'h1;
   logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, wakeRequest = 1'h0;
   logic extIrqPinZero = 1'h1, extIrqPinOne = 1'h1, extRomMode = 1'h0;
   logic countPinZero = 1'h0, countPinOne = 1'h0;
   logic fetchStrobeRun = 1'h1, latchStrobeRun = 1'h1;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000, portLatch = LATCH, portOutRun = RUNV;
   logic [31:0] portOeRun = 32'hF0F0_0FF0;
   logic [31:0] prdata, portOut, portOe, portInEn, pinLevel, rd;
   logic pready, pslverr, programFetchStrobe, addressLatchStrobe, oscHalt, err;
   int n_errors = 0;
   int samples_checked = 0;
   spd_power_ctrl spd_power_ctrl_inst (.*);
   spd_board_model spd_board_model_inst (.*);
   always #10 core_clk = ~core_clk;
   task automatic close_out;
      $display("checks %0d errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : close_out
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
   endtask : tick
   task automatic apb(input logic w, input logic [9:0] idx, input logic [31:0] d);
      @(posedge core_clk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= {idx, 2'h0};
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'h1;
      @(posedge core_clk);
      while (pready !== 1'h1) @(posedge core_clk);
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask : apb
   task automatic refuse_check(input logic [31:0] pwrCtrl);
      apb(1'h1, spd_pkg::PWR_CTRL_IDX, pwrCtrl);
      tick(2);
      chk(oscHalt, 1'h0);
      apb(1'h0, spd_pkg::STATUS_IDX, 32'h0000_0000);
      chk(rd[1:0], 2'h2);
      apb(1'h1, spd_pkg::STATUS_IDX, 32'h0000_0002);
   endtask : refuse_check
   task automatic s_regs;
      logic [9:0] ids [5];
      ids = '{spd_pkg::PWR_CTRL_IDX, spd_pkg::IO_CTRL_IDX, spd_pkg::WAKE_EN_IDX,
         spd_pkg::TMR_CTRL_IDX, spd_pkg::STATUS_IDX};
      foreach (ids[i]) begin
         apb(1'h0, ids[i], 32'h0000_0000);
         chk(rd, spd_pkg::DATA_ZERO);
      end
      // an unmapped all-ones write must not alias onto the mode bit
      apb(1'h1, 10'h3FF, 32'hFFFF_FFFF);
      chk(err, 1'h1);
      apb(1'h0, 10'h3FF, 32'h0000_0000);
      chk(rd, spd_pkg::DATA_ZERO);
      chk(oscHalt, 1'h0);
      chk(portOut, RUNV);
      chk(pready, 1'h1);
   endtask : s_regs
   task automatic s_refuse_irq;
      for (int i = 0; i < 4; i++) begin
         apb(1'h1, spd_pkg::WAKE_EN_IDX, (i < 2) ? 32'h0000_0001 << i : 32'h0000_0000);
         apb(1'h1, spd_pkg::PWR_CTRL_IDX, (i < 2) ? 32'h0000_0000 : 32'h0000_0020);
         extIrqPinZero <= i[0];
         extIrqPinOne <= !i[0];
         refuse_check((i < 2) ? 32'h0000_0002 : 32'h0000_0022);
      end
      extIrqPinZero <= 1'h1;
      extIrqPinOne <= 1'h1;
      apb(1'h1, spd_pkg::PWR_CTRL_IDX, 32'h0000_0000);
   endtask : s_refuse_irq
   task automatic s_refuse_tmr;
      for (int i = 0; i < 2; i++) begin
         // pin raised before the load so no count edge follows it
         countPinZero <= !i[0];
         countPinOne <= i[0];
         apb(1'h1, spd_pkg::TMR_CTRL_IDX, 32'h0000_000A);
         apb(1'h1, spd_pkg::TMR_CNT_IDX, 32'h0000_FFFF);
         apb(1'h1, spd_pkg::WAKE_EN_IDX, 32'h0000_0004 << i);
         refuse_check(32'h0000_0002);
      end
      countPinZero <= 1'h0;
      countPinOne <= 1'h0;
      apb(1'h1, spd_pkg::WAKE_EN_IDX, 32'h0000_0000);
   endtask : s_refuse_tmr
   task automatic s_enter(input logic flt, input logic rom);
      logic [7:0] held;
      // counts loaded first, so the external-mode timer 0 wraps from FE after two count pin edges in power down and flags overflow
      apb(1'h1, spd_pkg::TMR_CNT_IDX, 32'h0000_00FE);
      apb(1'h1, spd_pkg::TMR_CTRL_IDX, 32'h0000_0007);
      apb(1'h1, spd_pkg::IO_CTRL_IDX, {31'h0, flt});
      extRomMode <= rom;
      // a low pin whose source is not enabled must not block entry
      extIrqPinOne <= !rom;
      apb(1'h1, spd_pkg::PWR_CTRL_IDX, 32'h0000_0002);
      tick(2);
      chk(oscHalt, 1'h1);
      chk({programFetchStrobe, addressLatchStrobe}, 2'h0);
      if (flt) begin
         chk(pinLevel, spd_pkg::PINS_ALL);
         chk(portInEn, spd_pkg::P3_WAKE_INPUTS);
      end else begin
         chk(pinLevel, LATCH | (rom ? spd_pkg::PORT0_PINS : '0));
      end
      apb(1'h0, spd_pkg::TMR_CNT_IDX, 32'h0000_0000);
      held = rd[15:8];
      repeat (2) begin
         countPinZero <= 1'h1;
         tick(1);
         countPinZero <= 1'h0;
         tick(1);
      end
      apb(1'h0, spd_pkg::PWR_CTRL_IDX, 32'h0000_0000);
      chk(rd[1], 1'h1);
      apb(1'h0, spd_pkg::TMR_CNT_IDX, 32'h0000_0000);
      chk(rd[15:8], held);
      wakeRequest <= 1'h1;
      extIrqPinOne <= 1'h1;
      tick(1);
      wakeRequest <= 1'h0;
      tick(2);
      chk(portOut, RUNV);
      chk(portOe, portOeRun);
      chk(portInEn, spd_pkg::PINS_ALL);
      chk({programFetchStrobe, addressLatchStrobe}, 2'h3);
      apb(1'h0, spd_pkg::TMR_CNT_IDX, 32'h0000_0000);
      chk(rd[7:0], 8'h00);
      chk(rd[15:8] > held, 1'h1);
      apb(1'h0, spd_pkg::STATUS_IDX, 32'h0000_0000);
      chk(rd[3:0], 4'h4);
      apb(1'h1, spd_pkg::STATUS_IDX, 32'h0000_0004);
   endtask : s_enter
   initial begin
      #(20 * 6000);
      n_errors++;
      close_out;
   end
   initial begin
      repeat (12) @(posedge core_clk);
      sys_rst <= 1'h0;
      s_regs;
      s_refuse_irq;
      s_refuse_tmr;
      for (int k = 0; k < 4; k++) s_enter(k[0], k[1]);
      close_out;
   end
endmodule : spd_power_ctrl_bench
`default_nettype wire
